// file: src/usdp_top.sv
/*
 * usdp_top: shadow receive/transmit data port of a serial controller,
 * an APB slave with receive and transmit FIFOs, line status, interrupts
 * and an 8N1 serial or infrared line.
 * assumes line inputs synchronous to clk and a standard APB master.
 */
`timescale 1ns/100ps
// Function
// - sixteen word aliases all reach the same receive and transmit data path
// - alias read returns received byte in bits 7:0, serial or infrared input
// - received byte valid only while data-ready flag is set
// - fifos off: new byte overwrites unread byte and flags overrun
// - fifos on: alias read returns and pops the receive fifo head
// - receive fifo full: keep entries, drop newcomer, flag overrun
// - written byte goes out on serial line or active-low infrared output
// - fifos off: one write clears the transmit-holding-empty flag
// - fifos off: further writes before flag sets replace the pending byte
// - fifos on: up to sixteen bytes accepted before transmit fifo full
// - write while transmit fifo full is discarded, contents unchanged
module usdp_top
    import usdp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sin,
    input wire logic sir_in,
    output logic sout,
    output logic sir_out_n,
    output logic irq
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic fifo_en;
        logic ir_mode;
        logic [DATA_W-1:0] rx_hold;
        logic rx_hold_valid;
        logic overrun;
        logic [DATA_W-1:0] tx_hold;
        logic tx_hold_valid;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_en;
        logic irq;
        logic hold_empty_q;
        usdp_tx_state_t tx_state;
        logic [CNT_W-1:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [DATA_W-1:0] tx_shift;
        logic sout;
        logic sir_out_n;
    } usdp_st_t;

    usdp_st_t st_r;
    usdp_st_t st_nxt;

    logic acc;
    logic rd;
    logic wr;
    logic hit_alias;
    logic alias_rd;
    logic alias_wr;
    logic rx_line;
    logic rx_valid;
    logic [DATA_W-1:0] rx_data;
    logic rxf_in_ready;
    logic rxf_out_valid;
    logic rxf_pop;
    logic [DATA_W-1:0] rxf_out_data;
    logic txf_push;
    logic txf_in_ready;
    logic txf_out_valid;
    logic txf_pop;
    logic [DATA_W-1:0] txf_out_data;
    logic flush;
    logic data_ready;
    logic hold_empty;
    logic tx_load;
    logic [DATA_W-1:0] tx_next_byte;
    logic ev_overrun;
    logic new_fifo_en;
    logic [INT_W-1:0] events;
    logic tx_line;

    // one-wait-state slave: effects happen on the first access cycle
    assign acc = psel && penable && !st_r.pready;
    assign rd = acc && !pwrite;
    assign wr = acc && pwrite;
    assign hit_alias = (paddr >= ADDR_SHADOW_BASE) && (paddr < ADDR_SHADOW_END) && (paddr[1:0] == 2'h0);
    assign alias_rd = rd && hit_alias;
    assign alias_wr = wr && hit_alias;

    // infrared input taken as an inverted, already stretched level
    assign rx_line = st_r.ir_mode ? !sir_in : sin;

    usdp_ser_rx u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .line_in(rx_line),
        .byte_valid(rx_valid),
        .byte_data(rx_data)
    );

    // changing fifo mode empties both fifos
    assign new_fifo_en = (wr && paddr == ADDR_CTRL) ? pwdata[CTRL_FIFO_EN_BIT] : st_r.fifo_en;
    assign flush = new_fifo_en != st_r.fifo_en;

    usdp_fifo u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flush),
        .in_valid(rx_valid && st_r.fifo_en),
        .in_ready(rxf_in_ready),
        .in_data(rx_data),
        .out_valid(rxf_out_valid),
        .out_ready(rxf_pop),
        .out_data(rxf_out_data)
    );

    assign rxf_pop = alias_rd && st_r.fifo_en;

    assign txf_push = alias_wr && st_r.fifo_en;

    usdp_fifo u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flush),
        .in_valid(txf_push),
        .in_ready(txf_in_ready),
        .in_data(pwdata[DATA_W-1:0]),
        .out_valid(txf_out_valid),
        .out_ready(txf_pop),
        .out_data(txf_out_data)
    );

    assign data_ready = st_r.fifo_en ? rxf_out_valid : st_r.rx_hold_valid;
    assign hold_empty = st_r.fifo_en ? !txf_out_valid : !st_r.tx_hold_valid;
    assign tx_load = (st_r.tx_state == TX_IDLE) && !hold_empty;
    assign txf_pop = tx_load && st_r.fifo_en;
    assign tx_next_byte = st_r.fifo_en ? txf_out_data : st_r.tx_hold;
    assign ev_overrun = rx_valid && (st_r.fifo_en ? !rxf_in_ready : st_r.rx_hold_valid);
    assign events = {hold_empty && !st_r.hold_empty_q, ev_overrun, rx_valid};

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pready = acc;
        st_nxt.pslverr = 1'b0;
        st_nxt.hold_empty_q = hold_empty;
        if (acc)
            st_nxt.prdata = '0;
        // receive holding byte, fifos off
        if (rx_valid && !st_r.fifo_en)
        begin
            st_nxt.rx_hold = rx_data;
            st_nxt.rx_hold_valid = 1'b1;
        end
        else if (alias_rd && !st_r.fifo_en)
            st_nxt.rx_hold_valid = 1'b0;
        // transmit holding byte, fifos off
        if (tx_load && !st_r.fifo_en)
            st_nxt.tx_hold_valid = 1'b0;
        if (alias_wr && !st_r.fifo_en)
        begin
            st_nxt.tx_hold = pwdata[DATA_W-1:0];
            st_nxt.tx_hold_valid = 1'b1;
        end
        if (rd)
        begin
            if (hit_alias)
                st_nxt.prdata = {24'h000000, st_r.fifo_en ? rxf_out_data : st_r.rx_hold};
            else if (paddr == ADDR_CTRL)
                st_nxt.prdata = {30'h00000000, st_r.ir_mode, st_r.fifo_en};
            else if (paddr == ADDR_LINE_STATUS)
            begin
                st_nxt.prdata[LS_DATA_READY_BIT] = data_ready;
                st_nxt.prdata[LS_OVERRUN_BIT] = st_r.overrun;
                st_nxt.prdata[LS_HOLD_EMPTY_BIT] = hold_empty;
                st_nxt.prdata[LS_TX_IDLE_BIT] = hold_empty && (st_r.tx_state == TX_IDLE);
            end
            else if (paddr == ADDR_INT_STATUS)
                st_nxt.prdata = {29'h00000000, st_r.int_stat};
            else if (paddr == ADDR_INT_ENABLE)
                st_nxt.prdata = {29'h00000000, st_r.int_en};
            else if (paddr != ADDR_INT_CLEAR)
                st_nxt.pslverr = 1'b1;
        end
        if (wr)
        begin
            if (paddr == ADDR_CTRL)
            begin
                st_nxt.fifo_en = pwdata[CTRL_FIFO_EN_BIT];
                st_nxt.ir_mode = pwdata[CTRL_IR_MODE_BIT];
            end
            else if (paddr == ADDR_INT_ENABLE)
                st_nxt.int_en = pwdata[INT_W-1:0];
            else if (!hit_alias && paddr != ADDR_INT_CLEAR && paddr != ADDR_LINE_STATUS
                     && paddr != ADDR_INT_STATUS)
                st_nxt.pslverr = 1'b1;
        end
        if (flush)
            st_nxt.rx_hold_valid = 1'b0;
        // overrun clears on a line status read; a new overrun wins
        if (rd && paddr == ADDR_LINE_STATUS)
            st_nxt.overrun = 1'b0;
        if (ev_overrun)
            st_nxt.overrun = 1'b1;
        // sticky interrupt status: set beats clear
        if (wr && paddr == ADDR_INT_CLEAR)
            st_nxt.int_stat = st_r.int_stat & ~pwdata[INT_W-1:0];
        st_nxt.int_stat = st_nxt.int_stat | events;
        st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_en);
        // transmitter, 8N1
        st_nxt.tx_cnt = st_r.tx_cnt + 1'b1;
        case (st_r.tx_state)
            TX_IDLE:
            begin
                st_nxt.tx_cnt = '0;
                if (tx_load)
                begin
                    st_nxt.tx_shift = tx_next_byte;
                    st_nxt.tx_state = TX_START;
                end
            end
            TX_START:
                if (st_r.tx_cnt == BIT_LAST)
                begin
                    st_nxt.tx_cnt = '0;
                    st_nxt.tx_bit = '0;
                    st_nxt.tx_state = TX_DATA;
                end
            TX_DATA:
                if (st_r.tx_cnt == BIT_LAST)
                begin
                    st_nxt.tx_cnt = '0;
                    st_nxt.tx_shift = {1'b0, st_r.tx_shift[DATA_W-1:1]};
                    st_nxt.tx_bit = st_r.tx_bit + 1'b1;
                    if (st_r.tx_bit == 3'h7)
                        st_nxt.tx_state = TX_STOP;
                end
            TX_STOP:
                if (st_r.tx_cnt == BIT_LAST)
                    st_nxt.tx_state = TX_IDLE;
            default:
                st_nxt.tx_state = TX_IDLE;
        endcase
        // line level of the bit that will be on the wire next cycle
        case (st_nxt.tx_state)
            TX_START: tx_line = 1'b0;
            TX_DATA: tx_line = st_nxt.tx_shift[0];
            default: tx_line = 1'b1;
        endcase
        // infrared: short low pulse at the start of each zero bit
        st_nxt.sout = st_nxt.ir_mode ? 1'b1 : tx_line;
        st_nxt.sir_out_n = !(st_nxt.ir_mode && !tx_line && st_nxt.tx_cnt < IR_PULSE_LAST);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '{tx_state: TX_IDLE, fifo_en: CTRL_RESET[CTRL_FIFO_EN_BIT],
                      ir_mode: CTRL_RESET[CTRL_IR_MODE_BIT], int_stat: INT_RESET, int_en: INT_RESET,
                      hold_empty_q: 1'b1, sout: 1'b1, sir_out_n: 1'b1, default: '0};
        else
            st_r <= st_nxt;
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign sout = st_r.sout;
    assign sir_out_n = st_r.sir_out_n;
    assign irq = st_r.irq;

    property p_pready_wait;
        @(posedge clk) disable iff (!rst_n)
        psel && penable && !pready |=> pready;
    endproperty
    a_pready_wait: assert property (p_pready_wait) else $error("access not answered in one cycle");

    property p_pready_pulse;
        @(posedge clk) disable iff (!rst_n)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held two cycles");

    property p_alias_upper_zero;
        @(posedge clk) disable iff (!rst_n)
        alias_rd |=> pready && prdata[31:8] == 24'h000000 && !pslverr;
    endproperty
    a_alias_upper_zero: assert property (p_alias_upper_zero) else $error("alias upper bits not zero");

    property p_ovr_nofifo;
        @(posedge clk) disable iff (!rst_n)
        rx_valid && !st_r.fifo_en && st_r.rx_hold_valid |=> st_r.overrun && st_r.rx_hold == $past(rx_data);
    endproperty
    a_ovr_nofifo: assert property (p_ovr_nofifo) else $error("overwrite without overrun");

    property p_ovr_fifo;
        @(posedge clk) disable iff (!rst_n)
        rx_valid && st_r.fifo_en && !rxf_in_ready && !rxf_pop && !flush |=> st_r.overrun && !rxf_in_ready;
    endproperty
    a_ovr_fifo: assert property (p_ovr_fifo) else $error("full receive fifo overrun lost");

    property p_rd_pop;
        @(posedge clk) disable iff (!rst_n)
        alias_rd && st_r.fifo_en && rxf_out_valid |=> prdata[7:0] == $past(rxf_out_data);
    endproperty
    a_rd_pop: assert property (p_rd_pop) else $error("alias read not fifo head");

    property p_hold_empty_clear;
        @(posedge clk) disable iff (!rst_n)
        alias_wr && !st_r.fifo_en && !flush |=> !hold_empty && st_r.tx_hold == $past(pwdata[7:0]);
    endproperty
    a_hold_empty_clear: assert property (p_hold_empty_clear) else $error("write did not fill holding byte");

    property p_tx_full_drop;
        @(posedge clk) disable iff (!rst_n)
        alias_wr && st_r.fifo_en && !txf_in_ready && !txf_pop && !flush |=> !txf_in_ready;
    endproperty
    a_tx_full_drop: assert property (p_tx_full_drop) else $error("full transmit fifo changed");

    property p_irq_level;
        @(posedge clk) disable iff (!rst_n)
        (|(events & st_r.int_en)) && !(wr && paddr == ADDR_INT_ENABLE) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("enabled event did not raise irq");

    property p_start_bit;
        @(posedge clk) disable iff (!rst_n)
        tx_load && !st_r.ir_mode && !(wr && paddr == ADDR_CTRL) |=> !sout [*8];
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not low");
endmodule : usdp_top

// file: src/usdp_pkg.sv
/*
 * usdp_pkg: addresses, field positions, reset values and timing counts
 * for the shadow data port of the serial controller.
 * assumes a 25 MHz system clock and a 32-bit APB register bus.
 */
package usdp_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // sixteen word aliases of the data path
    localparam logic [31:0] ADDR_SHADOW_BASE = 32'h50001130;
    localparam logic [31:0] ADDR_SHADOW_SLOT2 = 32'h50001138;
    localparam logic [31:0] ADDR_SHADOW_SLOT3 = 32'h5000113C;
    localparam logic [31:0] ADDR_SHADOW_END = 32'h50001170;
    localparam logic [31:0] ADDR_CTRL = 32'h50001180;
    localparam logic [31:0] ADDR_LINE_STATUS = 32'h50001184;
    localparam logic [31:0] ADDR_INT_STATUS = 32'h50001188;
    localparam logic [31:0] ADDR_INT_ENABLE = 32'h5000118C;
    localparam logic [31:0] ADDR_INT_CLEAR = 32'h50001190;
    // control fields
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_MODE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // line status fields
    localparam int LS_DATA_READY_BIT = 0;
    localparam int LS_OVERRUN_BIT = 1;
    localparam int LS_HOLD_EMPTY_BIT = 5;
    localparam int LS_TX_IDLE_BIT = 6;
    // interrupt fields
    localparam int INT_W = 3;
    localparam int INT_RX_BIT = 0;
    localparam int INT_OVERRUN_BIT = 1;
    localparam int INT_HOLD_EMPTY_BIT = 2;
    localparam logic [INT_W-1:0] INT_RESET = 3'h0;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int BIT_TIME_NS = 8680;
    localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int HALF_BIT_CYC = BIT_CYC / 2;
    localparam int IR_PULSE_CYC = (BIT_CYC * 3) / 16;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_BIT_CYC - 1);
    localparam logic [CNT_W-1:0] IR_PULSE_LAST = CNT_W'(IR_PULSE_CYC);

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usdp_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usdp_rx_state_t;
endpackage : usdp_pkg

// file: src/usdp_fifo.sv
/*
 * usdp_fifo: small synchronous FIFO with valid/ready on both sides.
 * assumes one clock; flush empties it in one cycle.
 */
`timescale 1ns/100ps
module usdp_fifo
    import usdp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [usdp_pkg::DATA_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [usdp_pkg::DATA_W-1:0] out_data
);
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [FIFO_AW-1:0] wr_ptr;
        logic [FIFO_AW-1:0] rd_ptr;
        logic [FIFO_AW:0] count;
    } usdp_fifo_st_t;

    usdp_fifo_st_t st_r;
    usdp_fifo_st_t st_nxt;
    logic push;
    logic pop;

    assign in_ready = (st_r.count != (FIFO_AW+1)'(FIFO_DEPTH));
    assign out_valid = (st_r.count != '0);
    assign out_data = st_r.mem[st_r.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wr_ptr] = in_data;
            st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
        end
        if (pop)
            st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
        st_nxt.count = st_r.count + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
        if (flush)
        begin
            st_nxt.wr_ptr = '0;
            st_nxt.rd_ptr = '0;
            st_nxt.count = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule : usdp_fifo

// file: src/usdp_ser_rx.sv
/*
 * usdp_ser_rx: 8N1 receiver, one byte pulse per frame with a high stop bit.
 * assumes the line is synchronous to clk and idles high.
 */
`timescale 1ns/100ps
module usdp_ser_rx
    import usdp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    output logic byte_valid,
    output logic [usdp_pkg::DATA_W-1:0] byte_data
);
    typedef struct packed {
        usdp_rx_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [2:0] bit_idx;
        logic [DATA_W-1:0] shift;
        logic valid;
    } usdp_rx_st_t;

    usdp_rx_st_t st_r;
    usdp_rx_st_t st_nxt;

    assign byte_valid = st_r.valid;
    assign byte_data = st_r.shift;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        st_nxt.cnt = st_r.cnt + 1'b1;
        case (st_r.state)
            RX_IDLE:
            begin
                st_nxt.cnt = '0;
                if (!line_in)
                    st_nxt.state = RX_START;
            end
            RX_START:
                // re-check at mid-bit so glitches do not start a frame
                if (st_r.cnt == HALF_LAST)
                begin
                    st_nxt.cnt = '0;
                    st_nxt.bit_idx = '0;
                    st_nxt.state = line_in ? RX_IDLE : RX_DATA;
                end
            RX_DATA:
                if (st_r.cnt == BIT_LAST)
                begin
                    st_nxt.cnt = '0;
                    st_nxt.shift = {line_in, st_r.shift[DATA_W-1:1]};
                    st_nxt.bit_idx = st_r.bit_idx + 1'b1;
                    if (st_r.bit_idx == 3'h7)
                        st_nxt.state = RX_STOP;
                end
            RX_STOP:
                if (st_r.cnt == BIT_LAST)
                begin
                    st_nxt.valid = line_in;
                    st_nxt.state = RX_IDLE;
                end
            default:
                st_nxt.state = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '{state: RX_IDLE, default: '0};
        else
            st_r <= st_nxt;
    end
endmodule : usdp_ser_rx

// file: sim/usdp_line_model.sv
/*
 * usdp_line_model: remote 8N1 transceiver on the serial and infrared lines.
 * assumes lines synchronous to clk and the bit time of usdp_pkg.
 */
`timescale 1ns/100ps
module usdp_line_model
(
    input wire logic clk,
    input wire logic sout,
    input wire logic sir_out_n,
    input wire logic ir_mode,
    output logic sin,
    output logic sir_in
);
    import usdp_pkg::*;
    logic [7:0] got_q[$];

    initial
    begin
        sin = 1'b1;
        sir_in = 1'b0;
    end

    // infrared input high marks a zero bit, idle low
    task automatic send(input logic [7:0] b, input logic ir);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            sin <= ir ? 1'b1 : f[i];
            sir_in <= ir ? ~f[i] : 1'b0;
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask : send

    // infrared zero bits are short pulses, so sample inside the pulse
    always
    begin : rx_loop
        logic [7:0] b;
        int off;
        @(posedge clk);
        if ((ir_mode ? sir_out_n : sout) === 1'b0)
        begin
            off = ir_mode ? IR_PULSE_CYC / 2 : HALF_BIT_CYC;
            repeat (BIT_CYC + off) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                b[i] = ir_mode ? sir_out_n : sout;
                repeat (BIT_CYC) @(posedge clk);
            end
            got_q.push_back(b);
        end
    end
endmodule : usdp_line_model

// file: sim/uart_shadow_data_port_tb_top.sv
/*
 * uart_shadow_data_port_tb_top: self-checking bench of usdp_top with an APB
 * master and a remote line model. assumes usdp_pkg and usdp_line_model.
 */
`timescale 1ns/100ps
module uart_shadow_data_port_tb_top;
    import usdp_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, sin, sir_in, ir_mode, pready, pslverr, sout, sir_out_n, irq, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [31:0] seed = 32'h38DE029C;
    logic [7:0] t[20];
    logic [7:0] r[17];
    int miscompares = 0;
    int samples_checked = 0;
    int n;

    usdp_top usdp_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sin(sin),
        .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));
    usdp_line_model usdp_line_model_inst (.clk(clk), .sout(sout), .sir_out_n(sir_out_n), .ir_mode(ir_mode),
        .sin(sin), .sir_in(sir_in));

    initial
    begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic logic [31:0] slot(input logic [31:0] s);
        return ADDR_SHADOW_BASE + {26'h0, s[11:8], 2'b00};
    endfunction : slot

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k == 50)
            miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic poll(input logic [31:0] a, input int b);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, a, 32'h0);
            k++;
        end
        while (rd[b] !== 1'b1 && k < 400);
        if (rd[b] !== 1'b1)
            miscompares++;
    endtask : poll

    task automatic wait_got(input int m);
        int k;
        k = 0;
        while (usdp_line_model_inst.got_q.size() < m && k < 60000)
        begin
            @(posedge clk);
            k++;
        end
        if (usdp_line_model_inst.got_q.size() < m)
            miscompares++;
    endtask : wait_got

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        #(CLK_PERIOD_NS * 100000);
        miscompares++;
        stop_test();
    end

    initial
    begin
        {psel, penable, pwrite, ir_mode, rst_n} = 5'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_SHADOW_SLOT2, 32'h0);
        chk("slot2_reset", rd, 32'h0);
        apb(1'b0, ADDR_SHADOW_SLOT3, 32'h0);
        chk("slot3_reset", rd, 32'h0);
        apb(1'b0, ADDR_SHADOW_END + 32'h4, 32'h0);
        chk("unmapped_err", er, 1'b1);
        apb(1'b1, ADDR_INT_ENABLE, 32'h2);
        apb(1'b0, ADDR_INT_ENABLE, 32'h0);
        chk("int_enable", rd, 32'h2);
        $display("test reset done");
        for (int m = 0; m < 2; m++)
        begin
            ir_mode <= m[0];
            apb(1'b1, ADDR_CTRL, 32'(m << CTRL_IR_MODE_BIT));
            for (int i = 0; i < 2; i++)
            begin
                seed = xs(seed);
                r[i] = seed[7:0];
                usdp_line_model_inst.send(r[i], m[0]);
            end
            poll(ADDR_INT_STATUS, INT_OVERRUN_BIT);
            chk("irq_set", irq, 1'b1);
            apb(1'b1, ADDR_INT_CLEAR, 32'h7);
            apb(1'b0, ADDR_LINE_STATUS, 32'h0);
            chk("ready_overrun", rd[1:0], 2'h3);
            apb(1'b0, slot(seed), 32'h0);
            chk("rx_byte", rd, {24'h0, r[1]});
            apb(1'b0, ADDR_LINE_STATUS, 32'h0);
            chk("ready_clear", rd[0], 1'b0);
            chk("irq_clear", irq, 1'b0);
            poll(ADDR_LINE_STATUS, LS_HOLD_EMPTY_BIT);
            usdp_line_model_inst.got_q.delete();
            for (int i = 0; i < 3; i++)
            begin
                seed = xs(seed);
                t[i] = seed[7:0];
                apb(1'b1, slot(seed), seed);
                if (i == 1)
                begin
                    apb(1'b0, ADDR_LINE_STATUS, 32'h0);
                    chk("hold_empty", rd[LS_HOLD_EMPTY_BIT], 1'b0);
                end
            end
            wait_got(2);
            chk("tx_first", usdp_line_model_inst.got_q[0], t[0]);
            chk("tx_replaced", usdp_line_model_inst.got_q[1], t[2]);
            $display("test fifo off mode %0d done", m);
        end
        ir_mode <= 1'b0;
        // idle shifter takes the first byte at once, so exactly depth plus one go out
        poll(ADDR_LINE_STATUS, LS_TX_IDLE_BIT);
        apb(1'b1, ADDR_CTRL, 32'h1);
        usdp_line_model_inst.got_q.delete();
        for (int i = 0; i < 20; i++)
        begin
            seed = xs(seed);
            t[i] = seed[7:0];
            apb(1'b1, slot(seed), seed);
        end
        // transmit drains while the receive fifo fills past depth
        for (int i = 0; i < 17; i++)
        begin
            seed = xs(seed);
            r[i] = seed[7:0];
            usdp_line_model_inst.send(r[i], 1'b0);
        end
        poll(ADDR_INT_STATUS, INT_OVERRUN_BIT);
        apb(1'b0, ADDR_LINE_STATUS, 32'h0);
        chk("fifo_overrun", rd[1:0], 2'h3);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            seed = xs(seed);
            apb(1'b0, slot(seed), 32'h0);
            chk("rx_fifo_head", rd, {24'h0, r[i]});
        end
        apb(1'b0, ADDR_LINE_STATUS, 32'h0);
        chk("fifo_drained", rd[0], 1'b0);
        wait_got(FIFO_DEPTH);
        // room for any byte wrongly kept beyond the fifo and shifter
        repeat (30 * BIT_CYC) @(posedge clk);
        n = usdp_line_model_inst.got_q.size();
        chk("tx_count", n, FIFO_DEPTH + 1);
        for (int i = 0; i < n && i < 20; i++)
            chk("tx_fifo_byte", usdp_line_model_inst.got_q[i], t[i]);
        $display("test fifo on done");
        stop_test();
    end
endmodule : uart_shadow_data_port_tb_top
